// ==== rtl/bdm_data_mem.sv ====
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Data memory uses a 12-bit byte address, up to 4096 locations.
// [RQ2] Space is 16 banks of 256 bytes; one full general bank exists.
// [RQ3] Reads from unimplemented locations return zero.
// [RQ4] Banked address is bank pointer nibble above the 8-bit operand.
// [RQ5] Bank pointer keeps four low bits; upper bits read zero.
// [RQ6] Load-bank-literal instruction writes an immediate into the bank pointer.
// [RQ7] Writes to unimplemented banks are dropped; reads return zero.
// [RQ8] Status flags still update as if the access succeeded.
// [RQ9] Full-address move uses complete 12-bit addresses, never the bank pointer.
// [RQ10] Other instructions resolve 8-bit operands via bank pointer or access map.
// [RQ11] Access map: 00h-7Fh to bank 0 low, 80h-FFh to bank 15 high.
// [RQ12] Access-select one uses bank pointer with the operand.
// [RQ13] Access-select zero uses the access map, ignoring the bank pointer.
// [RQ14] Access-map accesses finish in one cycle, no pointer update needed.
// [RQ15] This access map applies only while the extended set bit is clear; the code keeps using it and raises map_unsupported_out.
// [RQ16] General RAM starts at 000h and grows upward.
// [RQ17] General RAM is never initialised or cleared by any reset.
// [RQ18] Special function registers occupy F80h through FFFh.
// [RQ19] Bank 0 and upper half of bank 15 are implemented; rest are not.
module bdm_data_mem
    import bdm_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic              extended_set_cfg_bit_in,
    input  wire logic              rd_en_in,
    input  wire logic              rd_full_in,
    input  wire logic              rd_access_sel_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    input  wire logic              wr_en_in,
    input  wire logic              wr_full_in,
    input  wire logic              wr_access_sel_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic              load_bank_literal_instr_in,
    input  wire logic [DATA_W-1:0] bank_literal_in,
    input  wire logic              status_update_in,
    output logic      [DATA_W-1:0] rd_data_out,
    output logic      [ADDR_W-1:0] rd_eff_addr_out,
    output logic                   rd_hit_out,
    output logic                   status_update_out,
    output logic      [DATA_W-1:0] bank_pointer_out,
    output logic                   map_unsupported_out
);
    // ----------------------------------------------------------------
    // Address formation
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] bank_pointer_q;
    logic [DATA_W-1:0] bank_pointer_d;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;

    function automatic logic [ADDR_W-1:0] resolve(
        input logic              full,
        input logic              acc_sel,
        input logic [ADDR_W-1:0] addr,
        input logic [BANK_W-1:0] bank
    );
        logic [OFFS_W-1:0] offs;
        offs = addr[OFFS_W-1:0];
        if (full) begin
            resolve = addr; // RQ9
        end else if (acc_sel) begin
            resolve = {bank, offs}; // RQ4
        end else if (offs < ACCESS_SPLIT) begin
            resolve = {GPR_BANK, offs}; // RQ11
        end else begin
            resolve = {SFR_BANK, offs}; // RQ11
        end
    endfunction

    // Operand-only instructions take banked or access path by the select bit.
    always_comb begin
        rd_addr = resolve(rd_full_in, rd_access_sel_in, rd_addr_in,
                          bank_pointer_q[BANK_W-1:0]); // RQ10 RQ12 RQ13
        wr_addr = resolve(wr_full_in, wr_access_sel_in, wr_addr_in,
                          bank_pointer_q[BANK_W-1:0]); // RQ10 RQ12 RQ13
    end

    // ----------------------------------------------------------------
    // Implemented region decode
    // ----------------------------------------------------------------
    logic rd_gpr;
    logic rd_sfr;
    logic rd_bsr;
    logic wr_gpr;
    logic wr_sfr;
    logic wr_bsr;

    always_comb begin
        rd_gpr = rd_addr[ADDR_W-1:OFFS_W] == GPR_BANK; // RQ2 RQ16 RQ19
        rd_sfr = rd_addr >= SFR_BASE; // RQ18 RQ19
        rd_bsr = rd_addr == BANK_PTR_ADDR;
        wr_gpr = wr_addr[ADDR_W-1:OFFS_W] == GPR_BANK; // RQ19
        wr_sfr = wr_addr >= SFR_BASE; // RQ18 RQ19
        wr_bsr = wr_addr == BANK_PTR_ADDR;
    end

    // ----------------------------------------------------------------
    // Bank pointer
    // ----------------------------------------------------------------
    always_comb begin
        bank_pointer_d = bank_pointer_q;
        if (load_bank_literal_instr_in) begin
            bank_pointer_d = bank_literal_in & BANK_PTR_MASK; // RQ6 RQ5
        end else if (wr_en_in && wr_bsr) begin
            bank_pointer_d = wr_data_in & BANK_PTR_MASK; // RQ5
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            bank_pointer_q <= BANK_PTR_RESET;
        end else begin
            bank_pointer_q <= bank_pointer_d;
        end
    end

    // ----------------------------------------------------------------
    // General purpose RAM
    // ----------------------------------------------------------------
    // No reset on purpose: contents survive every reset kind.
    logic [DATA_W-1:0] gpr_mem [GPR_BYTES]; // RQ17
    logic [DATA_W-1:0] gpr_rd_q;

    always_ff @(posedge clock_in) begin
        if (wr_en_in && wr_gpr) begin
            gpr_mem[wr_addr[OFFS_W-1:0]] <= wr_data_in; // RQ1 RQ7
        end
        gpr_rd_q <= gpr_mem[rd_addr[OFFS_W-1:0]];
    end

    // ----------------------------------------------------------------
    // Special function area
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] sfr_rd;

    bdm_sfr_store u_sfr (
        .clock_in    (clock_in),
        .rd_index_in (rd_addr[6:0]),
        .wr_index_in (wr_addr[6:0]),
        .wr_en_in    (wr_en_in && wr_sfr && !wr_bsr), // RQ7
        .wr_data_in  (wr_data_in),
        .rd_data_out (sfr_rd)
    );

    // ----------------------------------------------------------------
    // Read return
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BDM_SRC_ZERO = 2'h0,
        BDM_SRC_GPR  = 2'h1,
        BDM_SRC_SFR  = 2'h3,
        BDM_SRC_BSR  = 2'h2
    } bdm_src_t;

    bdm_src_t          src_q;
    bdm_src_t          src_d;
    logic [ADDR_W-1:0] rd_eff_q;
    logic              hit_q;
    logic              stat_q;
    logic [DATA_W-1:0] bsr_rd_q;

    always_comb begin
        src_d = BDM_SRC_ZERO; // RQ3 RQ7
        if (rd_en_in && rd_bsr) begin
            src_d = BDM_SRC_BSR;
        end else if (rd_en_in && rd_gpr) begin
            src_d = BDM_SRC_GPR;
        end else if (rd_en_in && rd_sfr) begin
            src_d = BDM_SRC_SFR;
        end
    end

    // Flags and read data answer one cycle after the request, whatever the target.
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            src_q    <= BDM_SRC_ZERO;
            rd_eff_q <= GPR_BASE;
            hit_q    <= 1'b0;
            stat_q   <= 1'b0;
            bsr_rd_q <= BANK_PTR_RESET;
        end else begin
            src_q    <= src_d; // RQ14
            rd_eff_q <= rd_addr;
            hit_q    <= src_d != BDM_SRC_ZERO;
            stat_q   <= status_update_in; // RQ8
            bsr_rd_q <= bank_pointer_q & BANK_PTR_MASK; // RQ5
        end
    end

    always_comb begin
        unique case (src_q)
            BDM_SRC_GPR:  rd_data_out = gpr_rd_q;
            BDM_SRC_SFR:  rd_data_out = sfr_rd;
            BDM_SRC_BSR:  rd_data_out = bsr_rd_q;
            BDM_SRC_ZERO: rd_data_out = '0; // RQ3
        endcase
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign rd_eff_addr_out     = rd_eff_q;
    assign rd_hit_out          = hit_q;
    assign status_update_out   = stat_q; // RQ8
    assign bank_pointer_out    = bank_pointer_q;
    // Indexed remapping is not built; flagged so the core can trap it.
    assign map_unsupported_out = extended_set_cfg_bit_in; // RQ15
endmodule

// ==== rtl/bdm_pkg.sv ====
package bdm_pkg;
    // ----------------------------------------------------------------
    // Address space
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned MEM_BYTES     = 4096;
    localparam int unsigned NUM_BANKS     = 16;
    localparam int unsigned BANK_BYTES    = 256;
    localparam int unsigned BANK_W        = 4;
    localparam int unsigned OFFS_W        = 8;
    localparam int unsigned GPR_BYTES     = 256;
    localparam int unsigned SFR_BYTES     = 128;
    localparam logic [3:0]  GPR_BANK      = 4'h0;
    localparam logic [3:0]  SFR_BANK      = 4'hf;
    localparam logic [11:0] GPR_BASE      = 12'h000;
    localparam logic [11:0] SFR_BASE      = 12'hf80;
    localparam logic [11:0] SFR_TOP       = 12'hfff;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
    // ----------------------------------------------------------------
    // Bank pointer register
    // ----------------------------------------------------------------
    localparam logic [11:0] BANK_PTR_ADDR  = 12'hfe0;
    localparam logic [7:0]  BANK_PTR_RESET = 8'h00;
    localparam logic [7:0]  BANK_PTR_MASK  = 8'h0f;
endpackage

// ==== rtl/bdm_sfr_store.sv ====
`timescale 1ns/1ps
module bdm_sfr_store
    import bdm_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic [6:0]        rd_index_in,
    input  wire logic [6:0]        wr_index_in,
    input  wire logic              wr_en_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    output logic      [DATA_W-1:0] rd_data_out
);
    // ----------------------------------------------------------------
    // Special function storage
    // ----------------------------------------------------------------
    // Held as plain RAM with no reset so it maps onto an array macro.
    logic [DATA_W-1:0] mem [SFR_BYTES];

    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem[wr_index_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_index_in];
    end
endmodule

// ==== verif/bdm_data_mem_properties.sv ====
`timescale 1ns/1ps
module bdm_data_mem_properties (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        extended_set_cfg_bit_in,
    input wire logic        rd_en_in,
    input wire logic        rd_full_in,
    input wire logic        rd_access_sel_in,
    input wire logic [11:0] rd_addr_in,
    input wire logic        load_bank_literal_instr_in,
    input wire logic [7:0]  bank_literal_in,
    input wire logic        status_update_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic [11:0] rd_eff_addr_out,
    input wire logic        rd_hit_out,
    input wire logic        status_update_out,
    input wire logic [7:0]  bank_pointer_out,
    input wire logic        map_unsupported_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    wire logic rd_part = rd_en_in && !rd_full_in && !extended_set_cfg_bit_in;
    chk_status_echo: assert property (status_update_out == $past(status_update_in))
        else $error("status pulse not echoed");
    chk_ptr_upper_zero: assert property (bank_pointer_out[7:4] == 4'h0)
        else $error("bank pointer upper bits set");
    chk_literal_load: assert property (load_bank_literal_instr_in |=>
        bank_pointer_out == {4'h0, $past(bank_literal_in[3:0])}) else $error("literal not loaded");
    chk_miss_reads_zero: assert property (!rd_hit_out |-> rd_data_out == 8'h00)
        else $error("miss returned data");
    chk_access_map: assert property (rd_part && !rd_access_sel_in |=> rd_hit_out &&
        rd_eff_addr_out == {{4{$past(rd_addr_in[7])}}, $past(rd_addr_in[7:0])})
        else $error("access map address wrong");
    chk_banked_addr: assert property (rd_part && rd_access_sel_in |=>
        rd_eff_addr_out == {$past(bank_pointer_out[3:0]), $past(rd_addr_in[7:0])})
        else $error("banked address wrong");
    chk_full_addr: assert property (rd_en_in && rd_full_in |=>
        rd_eff_addr_out == $past(rd_addr_in)) else $error("full address wrong");
    chk_hit_region: assert property ($past(rd_en_in) |-> rd_hit_out ==
        (rd_eff_addr_out[11:8] == 4'h0 || rd_eff_addr_out[11:7] == 5'h1f))
        else $error("hit flag wrong");
    chk_map_flag: assert property (map_unsupported_out == extended_set_cfg_bit_in)
        else $error("map flag wrong");
    cov_map_read: cover property (rd_part && !rd_access_sel_in);
    cov_banked: cover property (rd_part && rd_access_sel_in);
    cov_miss: cover property (rd_en_in ##1 !rd_hit_out);
endmodule
bind bdm_data_mem bdm_data_mem_properties u_bdm_data_mem_properties (
    .clock_in(clock_in), .reset_in(reset_in), .extended_set_cfg_bit_in(extended_set_cfg_bit_in),
    .rd_en_in(rd_en_in), .rd_full_in(rd_full_in), .rd_access_sel_in(rd_access_sel_in),
    .rd_addr_in(rd_addr_in), .load_bank_literal_instr_in(load_bank_literal_instr_in),
    .bank_literal_in(bank_literal_in), .status_update_in(status_update_in),
    .rd_data_out(rd_data_out), .rd_eff_addr_out(rd_eff_addr_out), .rd_hit_out(rd_hit_out),
    .status_update_out(status_update_out), .bank_pointer_out(bank_pointer_out),
    .map_unsupported_out(map_unsupported_out));

// ==== verif/bdm_core_model.sv ====
`timescale 1ns/1ps
module bdm_core_model (
    input  wire logic        clock_in,
    output logic [2:0]  en_out,
    output logic        full_out,
    output logic        sel_out,
    output logic [11:0] addr_out,
    output logic [7:0]  data_out,
    output logic        status_out
);
    initial {en_out, full_out, sel_out, addr_out, data_out, status_out} = '0;
    // Kind bits are literal load, write, read; each request lasts one cycle.
    task automatic op(input logic [2:0] kind, input logic full, input logic sel,
                      input logic [11:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        {en_out, full_out, sel_out, addr_out, data_out} <= {kind, full, sel, addr, data};
        status_out <= kind[1];
        @(posedge clock_in);
        {en_out, status_out} <= 4'h0;
        // Released lines flip so a stale operand can never pass for a fresh one.
        {addr_out, data_out} <= ~{addr, data};
    endtask
endmodule

// ==== verif/tb_bdm_data_mem.sv ====
`timescale 1ns/1ps
module tb_bdm_data_mem;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        ext = 1'b0;
    logic [2:0]  en;
    logic        full, sel, stat, stat_o, hit, unsup;
    logic [11:0] addr, eff;
    logic [7:0]  data, rdata, bptr;
    int          failures = 0;
    int          total_checks = 0;
    always #5 clock_in = ~clock_in;
    bdm_core_model u_bdm_core_model (.clock_in(clock_in), .en_out(en), .full_out(full),
        .sel_out(sel), .addr_out(addr), .data_out(data), .status_out(stat));
    bdm_data_mem u_bdm_data_mem (.clock_in(clock_in), .reset_in(reset_in),
        .extended_set_cfg_bit_in(ext), .rd_en_in(en[0]), .rd_full_in(full),
        .rd_access_sel_in(sel), .rd_addr_in(addr), .wr_en_in(en[1]), .wr_full_in(full),
        .wr_access_sel_in(sel), .wr_addr_in(addr), .wr_data_in(data),
        .load_bank_literal_instr_in(en[2]), .bank_literal_in(data), .status_update_in(stat),
        .rd_data_out(rdata), .rd_eff_addr_out(eff), .rd_hit_out(hit),
        .status_update_out(stat_o), .bank_pointer_out(bptr), .map_unsupported_out(unsup));
    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Answers are looked at 1 ns after the edge that takes the request, while they stand.
    task automatic rd(input logic f, input logic s, input logic [11:0] a,
                      input logic [11:0] ea, input logic [8:0] e);
        u_bdm_core_model.op(3'h1, f, s, a, 8'h00);
        #1;
        cmp("read data", {4'h0, e[7:0]}, {4'h0, rdata});
        cmp("read hit", {11'h0, e[8]}, {11'h0, hit});
        cmp("read address", ea, eff);
        cmp("read status", 12'h000, {11'h0, stat_o});
    endtask
    task automatic wr(input logic f, input logic s, input logic [11:0] a, input logic [7:0] d);
        u_bdm_core_model.op(3'h2, f, s, a, d);
        #1;
        cmp("write status", 12'h001, {11'h0, stat_o});
    endtask
    task automatic complete_run;
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        reset_in <= 1'b0;
        #1 cmp("pointer reset", 12'h000, {4'h0, bptr});
        wr(1'b0, 1'b0, 12'h005, 8'ha5);
        rd(1'b0, 1'b0, 12'h005, 12'h005, 9'h1a5);
        wr(1'b1, 1'b0, 12'h0ff, 8'h3c);
        rd(1'b0, 1'b1, 12'h0ff, 12'h0ff, 9'h13c);
        u_bdm_core_model.op(3'h4, 1'b0, 1'b0, 12'h000, 8'hf7);
        #1 cmp("pointer load", 12'h007, {4'h0, bptr});
        wr(1'b0, 1'b1, 12'h010, 8'h55);
        rd(1'b0, 1'b1, 12'h010, 12'h710, 9'h000);
        rd(1'b0, 1'b0, 12'h005, 12'h005, 9'h1a5);
        wr(1'b0, 1'b0, 12'h090, 8'h66);
        rd(1'b1, 1'b0, 12'hf90, 12'hf90, 9'h166);
        rd(1'b1, 1'b0, 12'hf10, 12'hf10, 9'h000);
        rd(1'b1, 1'b0, 12'h100, 12'h100, 9'h000);
        wr(1'b1, 1'b0, 12'hfe0, 8'hff);
        cmp("pointer write", 12'h00f, {4'h0, bptr});
        rd(1'b1, 1'b0, 12'hfe0, 12'hfe0, 9'h10f);
        rd(1'b0, 1'b1, 12'h090, 12'hf90, 9'h166);
        @(posedge clock_in) ext <= 1'b1;
        #1 cmp("map flag", 12'h001, {11'h0, unsup});
        @(posedge clock_in) {ext, reset_in} <= 2'b01;
        repeat (5) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(1'b0, 1'b0, 12'h005, 12'h005, 9'h1a5);
        cmp("pointer after reset", 12'h000, {4'h0, bptr});
        complete_run();
    end
endmodule
